// *** src/tmc_top.sv ***
// compare function of four capture/compare units with a shared timer
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/100ps

// Notes on behaviour
// - each unit compares its 16-bit match pair with the timer every cycle.
// - a match performs the one action chosen by the 4-bit mode field.
// - every compare mode sets the unit flag in the same cycle as the pin.
// - writing zero to a control register forces the output latch low.
// - mode 1010 raises only the flag and leaves the pin to port logic.
// - mode 1011 resets the timer and starts a conversion if enabled.
// - in special trigger mode the unit never drives its pin.
// - special trigger output rises at once when count equals match.
// - timer clears on the next timer tick following the match.
// - a special trigger reset never sets the timer overflow flag.
// - if the match is gone by the next tick, the timer reset is skipped.
// - four units, each with own control, match, flag and pin; units 2 and 3 keep only control bits 5:0.
module tmc_top
  import tmc_pkg::*;
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 timer_tick_pin,
  input  wire logic                 adc_enable,
  output logic                      adc_start,
  output logic                      special_trigger,
  output logic [NUM_UNITS-1:0]      compare_output_pin,
  output logic [NUM_UNITS-1:0]      compare_output_oe,
  output logic                      irq
);

  // -------------------------------------------------------------------
  // declarations
  // -------------------------------------------------------------------
  logic [7:0]           aw_addr_r;
  logic                 aw_full_r;
  logic [7:0]           w_data_r;
  logic                 w_strb0_r;
  logic                 w_full_r;
  logic                 bvalid_r;
  logic [1:0]           bresp_r;
  logic                 rvalid_r;
  logic [1:0]           rresp_r;
  logic [31:0]          rdata_r;
  logic                 wr_fire;
  logic                 wr_hit;
  logic                 rd_fire;
  logic                 rd_hit;
  logic [7:0]           rd_byte;
  logic [7:0]           ctrl_r   [NUM_UNITS];
  logic [15:0]          match_r  [NUM_UNITS];
  logic [15:0]          count_r;
  logic [4:0]           status_r;
  logic [4:0]           mask_r;
  logic [NUM_UNITS-1:0] latch_r;
  logic [NUM_UNITS-1:0] match_prev_r;
  logic [NUM_UNITS-1:0] match_now;
  logic [NUM_UNITS-1:0] match_ev;
  logic [NUM_UNITS-1:0] is_special;
  logic [NUM_UNITS-1:0] flag_set;
  logic                 tick_s1_r;
  logic                 tick_s2_r;
  logic                 tick_s3_r;
  logic                 tick;
  logic                 timer_reset;
  logic                 timer_wrap;
  logic                 stat_clr;
  logic                 cnt_wr;

  // -------------------------------------------------------------------
  // address decode helpers
  // -------------------------------------------------------------------
  // map: unit n sits at n*0x10 with control +0x00, match low +0x04
  // and match high +0x08; +0x0c is a hole that answers with an error
  // timer count low 0x40, high 0x44, status 0x48, mask 0x4c
  // status bits 3:0 are the unit flags, bit 4 the timer overflow
  // each register is one byte in lane 0 of an aligned word; misaligned
  // or unmapped words answer with an error and change nothing
  function automatic logic addr_ok(input logic [7:0] a);
    logic ok;
    ok = 1'b0;
    if (a[1:0] != 2'b00) begin
      ok = 1'b0;
    end else if (a < UNIT_STRIDE * 4) begin
      ok = (a[3:0] != 4'hc);
    end else begin
      ok = (a == OFS_TLOW) || (a == OFS_THIGH) ||
           (a == OFS_STATUS) || (a == OFS_MASK);
    end
    return ok;
  endfunction

  function automatic logic is_cmp_mode(input logic [3:0] m);
    return (m == MODE_TOGGLE) || (m == MODE_SET) || (m == MODE_CLEAR) ||
           (m == MODE_SWINT) || (m == MODE_SPECIAL);
  endfunction

  // -------------------------------------------------------------------
  // write channel: address and data taken in either order
  // -------------------------------------------------------------------
  assign s_axi_awready = ~aw_full_r;
  assign s_axi_wready  = ~w_full_r;
  assign wr_fire       = aw_full_r & w_full_r & ~bvalid_r;
  assign wr_hit        = wr_fire & addr_ok(aw_addr_r) & w_strb0_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;

  // hold the write address until both halves are present
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end else if (s_axi_awvalid && !aw_full_r) begin
      aw_full_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_full_r <= 1'b0;
    end
  end

  // only the low byte lane carries register data; 8-bit registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_r  <= 1'b0;
      w_data_r  <= 8'h00;
      w_strb0_r <= 1'b0;
    end else if (s_axi_wvalid && !w_full_r) begin
      w_full_r  <= 1'b1;
      w_data_r  <= s_axi_wdata[7:0];
      w_strb0_r <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_full_r <= 1'b0;
    end
  end

  // a zero strobe on lane 0 still answers okay but writes nothing
  // write response one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= addr_ok(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // read channel
  // -------------------------------------------------------------------
  assign s_axi_arready = ~rvalid_r;
  assign rd_fire       = s_axi_arvalid & ~rvalid_r;
  assign rd_hit        = rd_fire & addr_ok(s_axi_araddr);
  assign stat_clr      = rd_hit & (s_axi_araddr == OFS_STATUS);
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // reading status is the only read with a side effect; a bus monitor
  // or debugger that peeks at 0x48 clears pending flags, so software
  // must collect every flag from the one read it makes
  // read data mux; unmapped addresses return zero
  always_comb begin
    rd_byte = 8'h00;
    if (s_axi_araddr < UNIT_STRIDE * 4) begin
      case (s_axi_araddr[3:0])
        OFS_CTRL[3:0]:  rd_byte = ctrl_r[s_axi_araddr[5:4]];
        OFS_MLOW[3:0]:  rd_byte = match_r[s_axi_araddr[5:4]][7:0];
        OFS_MHIGH[3:0]: rd_byte = match_r[s_axi_araddr[5:4]][15:8];
        default:        rd_byte = 8'h00;
      endcase
    end else begin
      case (s_axi_araddr)
        OFS_TLOW:   rd_byte = count_r[7:0];
        OFS_THIGH:  rd_byte = count_r[15:8];
        OFS_STATUS: rd_byte = {3'b000, status_r};
        OFS_MASK:   rd_byte = {3'b000, mask_r};
        default:    rd_byte = 8'h00;
      endcase
    end
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rdata_r  <= {24'h00_0000, rd_byte};
      rresp_r  <= addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // timer tick input: two flops, then a rising edge detect
  // -------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_s1_r <= 1'b0;
      tick_s2_r <= 1'b0;
      tick_s3_r <= 1'b0;
    end else begin
      tick_s1_r <= timer_tick_pin;
      tick_s2_r <= tick_s1_r;
      tick_s3_r <= tick_s2_r;
    end
  end
  // the pin is sampled twice before logic looks at it; the third flop
  // only keeps the last level to find rising edges, which costs three
  // cycles of latency between the pin edge and the count step
  assign tick = tick_s2_r & ~tick_s3_r;

  // -------------------------------------------------------------------
  // shared timer
  // -------------------------------------------------------------------
  // the reset is decided at the tick itself, so a match pair rewritten
  // since the trigger edge no longer matches and the reset drops out
  assign timer_reset = tick & |(is_special & match_now);
  assign timer_wrap  = tick & ~timer_reset & ~cnt_wr &
                       (count_r == 16'hffff);

  // a count write wins over a tick in the same cycle; that tick is lost
  // and must not report an overflow either
  assign cnt_wr      = wr_hit &
                       (aw_addr_r == OFS_TLOW || aw_addr_r == OFS_THIGH);

  // software writes win over the tick in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= COUNT_RST;
    end else if (wr_hit && aw_addr_r == OFS_TLOW) begin
      count_r[7:0] <= w_data_r;
    end else if (wr_hit && aw_addr_r == OFS_THIGH) begin
      count_r[15:8] <= w_data_r;
    end else if (timer_reset) begin
      count_r <= COUNT_RST;
    end else if (tick) begin
      count_r <= count_r + 16'h0001;
    end
  end

  // -------------------------------------------------------------------
  // per-unit registers, match detect and pin latch
  // -------------------------------------------------------------------
  for (genvar i = 0; i < NUM_UNITS; i++) begin : g_unit
    localparam logic [7:0] BASE = 8'(i * 16);
    localparam logic [7:0] CMSK = (i < 2) ? CTRL_FULL_MSK : CTRL_STD_MSK;
    logic [3:0] mode;

    assign mode          = ctrl_r[i][MODE_LSB +: 4];
    assign match_now[i]  = (count_r == match_r[i]);
    assign match_ev[i]   = match_now[i] & ~match_prev_r[i];
    assign is_special[i] = (mode == MODE_SPECIAL);
    assign flag_set[i]   = match_ev[i] & is_cmp_mode(mode);
    // pin only driven in toggle, set and clear modes
    assign compare_output_oe[i] = (mode == MODE_TOGGLE) ||
                                  (mode == MODE_SET) ||
                                  (mode == MODE_CLEAR);

    // control register; upper bits absent on the standard units
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ctrl_r[i] <= CTRL_RST;
      end else if (wr_hit && aw_addr_r == BASE + OFS_CTRL) begin
        ctrl_r[i] <= w_data_r & CMSK;
      end
    end

    // the pair is written a byte at a time, so an update passes through
    // a mixed value that may match for a moment; software that cares
    // should put the unit in mode zero while it rewrites the pair
    // match register pair, one byte per register
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        match_r[i] <= MATCH_RST;
      end else if (wr_hit && aw_addr_r == BASE + OFS_MLOW) begin
        match_r[i][7:0] <= w_data_r;
      end else if (wr_hit && aw_addr_r == BASE + OFS_MHIGH) begin
        match_r[i][15:8] <= w_data_r;
      end
    end

    // one event per new match, even while the timer dwells on a value
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        match_prev_r[i] <= 1'b0;
      end else begin
        match_prev_r[i] <= match_now[i];
      end
    end

    // only a control word of zero forces the latch low; changing modes
    // keeps the level, so a set or clear mode starts from the old pin
    // compare output latch, updated in the cycle the flag is set
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        latch_r[i] <= 1'b0;
      end else if (wr_hit && aw_addr_r == BASE + OFS_CTRL &&
                   w_data_r == 8'h00) begin
        latch_r[i] <= 1'b0;
      end else if (match_ev[i]) begin
        case (mode)
          MODE_TOGGLE: latch_r[i] <= ~latch_r[i];
          MODE_SET:    latch_r[i] <= 1'b1;
          MODE_CLEAR:  latch_r[i] <= 1'b0;
          default:     latch_r[i] <= latch_r[i];
        endcase
      end
    end
  end

  assign compare_output_pin = latch_r;

  // -------------------------------------------------------------------
  // special trigger and conversion start
  // -------------------------------------------------------------------
  // the trigger is a level that stands while the count equals the match;
  // a converter that wants a pulse must find the edge itself
  // combinational so the trigger appears with the match itself
  assign special_trigger = |(is_special & match_now);
  assign adc_start       = special_trigger & adc_enable;

  // -------------------------------------------------------------------
  // sticky status, mask and interrupt
  // -------------------------------------------------------------------
  // no other path clears a flag: only the status read does
  // a read clears status, but an event in the same cycle survives;
  // the overflow bit ignores trigger resets since those never wrap
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= STAT_RST;
    end else begin
      status_r <= (stat_clr ? STAT_RST : status_r) |
                  {timer_wrap, flag_set};
    end
  end

  // interrupt mask, same layout as status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_r <= MASK_RST;
    end else if (wr_hit && aw_addr_r == OFS_MASK) begin
      mask_r <= w_data_r[4:0];
    end
  end

  // level output; it drops only on a status read or a mask write
  assign irq = |(status_r & mask_r);

endmodule

// *** src/tmc_pkg.sv ***
// constants shared by the timer match compare unit
package tmc_pkg;

  // -------------------------------------------------------------------
  // unit count and compare mode field encodings
  // -------------------------------------------------------------------
  localparam int         NUM_UNITS   = 4;
  localparam logic [3:0] MODE_OFF    = 4'h0;
  localparam logic [3:0] MODE_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_SET    = 4'h8;
  localparam logic [3:0] MODE_CLEAR  = 4'h9;
  localparam logic [3:0] MODE_SWINT  = 4'ha;
  localparam logic [3:0] MODE_SPECIAL = 4'hb;

  // -------------------------------------------------------------------
  // register byte offsets (8-bit address space)
  // -------------------------------------------------------------------
  localparam logic [7:0] UNIT_STRIDE = 8'h10;
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_MLOW    = 8'h04;
  localparam logic [7:0] OFS_MHIGH   = 8'h08;
  localparam logic [7:0] OFS_TLOW    = 8'h40;
  localparam logic [7:0] OFS_THIGH   = 8'h44;
  localparam logic [7:0] OFS_STATUS  = 8'h48;
  localparam logic [7:0] OFS_MASK    = 8'h4c;

  // -------------------------------------------------------------------
  // field positions and reset values
  // -------------------------------------------------------------------
  localparam int         MODE_LSB      = 0;
  localparam int         ST_OVF_BIT    = 4;
  localparam logic [7:0] CTRL_FULL_MSK = 8'hff;
  localparam logic [7:0] CTRL_STD_MSK  = 8'h3f;
  localparam logic [7:0] CTRL_RST      = 8'h00;
  localparam logic [15:0] MATCH_RST    = 16'h0000;
  localparam logic [15:0] COUNT_RST    = 16'h0000;
  localparam logic [4:0] STAT_RST      = 5'h00;
  localparam logic [4:0] MASK_RST      = 5'h00;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

endpackage

// *** sim/tmc_props.sv ***
// port assertions of the timer match compare unit
`timescale 1ns/100ps
module tmc_props
  import tmc_pkg::*;
(
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_awready,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_wready,
  input wire logic [1:0]           s_axi_bresp,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_bready,
  input wire logic                 s_axi_arready,
  input wire logic [31:0]          s_axi_rdata,
  input wire logic [1:0]           s_axi_rresp,
  input wire logic                 s_axi_rvalid,
  input wire logic                 s_axi_rready,
  input wire logic                 adc_enable,
  input wire logic                 adc_start,
  input wire logic                 special_trigger,
  input wire logic [NUM_UNITS-1:0] compare_output_oe,
  input wire logic                 irq
);
  // -----------------------------------------------------------------
  // relations between ports, all in the one clock domain
  // -----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  adc_gate_a: assert property (
    adc_start == (special_trigger && adc_enable))
    else $error("conversion start not gated by the trigger");
  oe_write_a: assert property (
    $changed(compare_output_oe) |-> $rose(s_axi_bvalid))
    else $error("pin enable changed without a register write");
  irq_sticky_a: assert property (
    $fell(irq) |-> $rose(s_axi_rvalid) || $rose(s_axi_bvalid))
    else $error("interrupt dropped without software action");
  b_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  r_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read address ready wrong");
  r_upper_a: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h0 &&
    (s_axi_rresp == RESP_OKAY || s_axi_rresp == RESP_SLVERR))
    else $error("read word carries bad upper bits or code");
  b_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");

  cover property ($rose(special_trigger));
  cover property ($rose(irq));
  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

bind tmc_top tmc_props tmc_props_u (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .adc_enable(adc_enable), .adc_start(adc_start),
  .special_trigger(special_trigger),
  .compare_output_oe(compare_output_oe), .irq(irq));

// *** sim/tmc_pin_load.sv ***
// load on the compare pins: pull-down where the unit releases a pin
`timescale 1ns/100ps
module tmc_pin_load
  import tmc_pkg::*;
(
  input  wire logic [NUM_UNITS-1:0] pin,
  input  wire logic [NUM_UNITS-1:0] oe,
  output logic      [NUM_UNITS-1:0] line
);
  // -----------------------------------------------------------------
  // wire level
  // -----------------------------------------------------------------
  // direction bits assumed cleared; a released pin reads the pull-down
  assign line = pin & oe;
endmodule

// *** sim/timer_match_compare_unit_tb.sv ***
// self-checking bench for the timer match compare unit
`timescale 1ns/100ps
module timer_match_compare_unit_tb;
  import tmc_pkg::*;
  logic        aclk, aresetn, awv, wv, bre, arv, rre, tick, adc_en;
  logic        awr, wrdy, bv, arr, rv, adc_st, trig, irq;
  logic [7:0]  awa, ara;
  logic [3:0]  ws, pin, oe, line;
  logic [1:0]  br, rr, resp;
  logic [31:0] wd, rd, v;
  int          bad_count, samples_checked, k;
  logic [3:0]  modes [4] = '{MODE_TOGGLE, MODE_CLEAR, MODE_SET, MODE_SWINT};
  logic        lexp  [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

  tmc_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rre), .timer_tick_pin(tick), .adc_enable(adc_en),
    .adc_start(adc_st), .special_trigger(trig),
    .compare_output_pin(pin), .compare_output_oe(oe), .irq(irq));
  tmc_pin_load load_u (.pin(pin), .oe(oe), .line(line));

  // -----------------------------------------------------------------
  // clock, checking and bus tasks
  // -----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task results;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // inputs move only at posedge, so negedge sampling sees the edge value
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic ra, rw, b;
    @(posedge aclk);
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do begin
      @(negedge aclk);
      ra = awr;
      rw = wrdy;
      b = bv;
      resp = br;
      @(posedge aclk);
      if (ra) awv <= 1'b0;
      if (rw) wv <= 1'b0;
    end while (!b);
    bre <= 1'b0;
  endtask

  task rd_t(input logic [7:0] a);
    logic ra, r;
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(negedge aclk);
      ra = arr;
      r = rv;
      v = rd;
      resp = rr;
      @(posedge aclk);
      if (ra) arv <= 1'b0;
    end while (!r);
    rre <= 1'b0;
  endtask

  // n timer clocks per call, each long enough for the sync and the pin edge
  task tk(input int n);
    repeat (n) begin
      tick <= 1'b1;
      repeat (2) @(posedge aclk);
      tick <= 1'b0;
      repeat (5) @(posedge aclk);
    end
  endtask

  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  initial begin
    {aresetn, awv, wv, bre, arv, rre, tick, adc_en} = 8'h00;
    {awa, ara, wd} = 48'h0;
    ws = 4'h1;
    bad_count = 0;
    samples_checked = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd_t(OFS_CTRL);
    chk(v, 32'h0);
    rd_t(8'h0c);
    chk(32'(resp), 32'(RESP_SLVERR));
    wr(8'h0c, 8'h55);
    chk(32'(resp), 32'(RESP_SLVERR));
    // unit four sets its pin, flag raises irq and stays until read
    wr(OFS_MASK, 8'h0f);
    wr(8'h34, 8'h02);
    wr(8'h30, {4'h0, MODE_SET});
    tk(1);
    chk({oe, line, 3'h0, irq}, 32'h800);
    tk(1);
    chk({oe, line, 3'h0, irq}, 32'h881);
    tk(1);
    chk(32'(irq), 32'h1);
    rd_t(OFS_STATUS);
    chk(v, 32'h08);
    chk(32'(irq), 32'h0);
    wr(8'h30, 8'h00);
    chk({oe, pin}, 32'h0);
    // mode table on unit two, one new match each pass
    wr(8'h14, 8'h01);
    for (k = 0; k < 4; k++) begin
      wr(8'h10, {4'h0, modes[k]});
      wr(OFS_TLOW, 8'h00);
      tk(1);
      chk(32'(line[1]), 32'(lexp[k]));
      rd_t(OFS_STATUS);
      chk(v, 32'h02);
    end
    wr(8'h10, 8'h00);
    // special trigger on unit four resets the timer
    adc_en <= 1'b1;
    wr(8'h34, 8'h03);
    wr(8'h30, {4'h0, MODE_SPECIAL});
    wr(OFS_TLOW, 8'h01);
    tk(2);
    chk({trig, adc_st, oe[3]}, 32'h6);
    tk(1);
    chk(32'(trig), 32'h0);
    rd_t(OFS_TLOW);
    chk(v, 32'h0);
    rd_t(OFS_STATUS);
    chk(v, 32'h08);
    // match moved away before the tick: timer keeps counting
    wr(OFS_TLOW, 8'h02);
    tk(1);
    chk(32'(trig), 32'h1);
    wr(8'h34, 8'h05);
    tk(1);
    rd_t(OFS_TLOW);
    chk(v, 32'h04);
    // pending flag masked, unmasked, then cleared
    wr(OFS_MASK, 8'h00);
    chk(32'(irq), 32'h0);
    wr(OFS_MASK, 8'h08);
    chk(32'(irq), 32'h1);
    rd_t(OFS_STATUS);
    chk(32'(irq), 32'h0);
    // wrap from ffff sets only the overflow bit
    wr(OFS_THIGH, 8'hff);
    wr(OFS_TLOW, 8'hff);
    tk(1);
    rd_t(OFS_STATUS);
    chk(v, 32'h10);
    results();
  end

  // watchdog far beyond the few hundred cycles the scenarios need
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    results();
  end
endmodule
